// [common/mms_pkg.sv]
package mms_pkg;
    localparam logic [7:0] ADDR_MEAS_CTRL = 8'hf4;
    localparam logic [7:0] ADDR_STBY_CFG = 8'hf5;
    localparam logic [7:0] MEAS_CTRL_RESET = 8'h00;
    localparam logic [7:0] STBY_CFG_RESET = 8'h00;
    localparam int MODE_LSB = 0;
    localparam int OSRS_P_LSB = 2;
    localparam int OSRS_T_LSB = 5;
    localparam int FILTER_LSB = 2;
    localparam int IDLE_SEL_LSB = 5;
    localparam logic [1:0] MODE_SLEEP = 2'h0;
    localparam logic [1:0] MODE_NORMAL = 2'h3;
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int TMR_W = 22;
    localparam logic [21:0] MEAS_BASE_US = 22'h00_03e8;
    localparam logic [21:0] TEMP_SAMPLE_US = 22'h00_07d0;
    localparam logic [21:0] PRES_SAMPLE_US = 22'h00_07d0;
    localparam logic [21:0] PRES_EXTRA_US = 22'h00_01f4;
    localparam logic [21:0] MEAS_MAX_LOW_US = 22'h00_1900;
    localparam logic [21:0] MEAS_MAX_HIGH_US = 22'h00_a8c0;
    localparam logic [21:0] STANDBY_US [8] = '{22'h00_01f4, 22'h00_f424, 22'h01_e848, 22'h03_d090,
                                               22'h07_a120, 22'h0f_4240, 22'h1e_8480, 22'h3d_0900};
    localparam logic [19:0] SKIP_VALUE = 20'h8_0000;

    typedef enum logic [4:0] {
        ST_SLEEP = 5'b00001,
        ST_TEMP = 5'b00010,
        ST_PRES = 5'b00100,
        ST_FILT = 5'b01000,
        ST_STBY = 5'b10000
    } mms_state_e;

    function automatic logic [4:0] osr_samples(input logic [2:0] code);
        case (code)
            3'h0: osr_samples = 5'h00;
            3'h1: osr_samples = 5'h01;
            3'h2: osr_samples = 5'h02;
            3'h3: osr_samples = 5'h04;
            3'h4: osr_samples = 5'h08;
            default: osr_samples = 5'h10;
        endcase
    endfunction : osr_samples

    function automatic logic is_forced(input logic [1:0] mode);
        is_forced = (mode != MODE_SLEEP) && (mode != MODE_NORMAL);
    endfunction : is_forced
endpackage : mms_pkg

// [logic/mms_interval_timer.sv]
`timescale 1ns/1ps
module mms_interval_timer #(
    parameter int P_TICK_CYCLES = mms_pkg::TICK_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_load,
    input wire logic [mms_pkg::TMR_W-1:0] i_ticks,
    output logic o_done
);
    logic [15:0] pre_reg;
    logic [mms_pkg::TMR_W-1:0] cnt_reg;
    logic run_reg;
    logic tick;

    // Prescaler restarts on every load, so timing never depends on host clocks
    assign tick = (pre_reg == 16'h0000);

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            pre_reg <= 16'h0000;
        end else if (tick || i_load) begin
            pre_reg <= 16'(P_TICK_CYCLES - 1);
        end else begin
            pre_reg <= pre_reg - 16'h0001;
        end
    end

    // Load wins over expiry so back-to-back phases chain cleanly
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_load) begin
                cnt_reg <= i_ticks;
                run_reg <= 1'b1;
            end else if (run_reg && tick) begin
                cnt_reg <= cnt_reg - 22'h00_0001;
                if (cnt_reg <= 22'h00_0001) begin
                    run_reg <= 1'b0;
                    o_done <= 1'b1;
                end
            end
        end
    end
endmodule : mms_interval_timer

// [logic/mms_scheduler.sv]
`timescale 1ns/1ps
module mms_scheduler #(
    parameter int P_TICK_CYCLES = mms_pkg::TICK_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic [19:0] i_temp_adc,
    input wire logic [19:0] i_press_adc,
    output logic o_temp_conv,
    output logic o_press_conv,
    output logic o_filter_step,
    output logic o_data_update,
    output logic [19:0] o_temp_data,
    output logic [19:0] o_press_data,
    output logic o_measuring,
    output logic o_mode_pending
);
    mms_pkg::mms_state_e state_reg, state_next;
    logic [5:0] osrs_reg, osrs_eff, osrs_meas_reg;
    logic [1:0] mode_reg, pend_mode_reg, wmode, mode_after;
    logic pend_reg;
    logic [7:0] cfg_reg;
    logic [19:0] temp_hold_reg;
    logic wr_ctrl, wr_cfg, busy, tmr_load, tmr_done;
    logic [4:0] nt_eff, np_eff, nt_meas, np_meas;
    logic [21:0] temp_us, pres_us, tmr_ticks;

    assign wr_ctrl = i_reg_wr && (i_reg_addr == mms_pkg::ADDR_MEAS_CTRL);
    assign wr_cfg = i_reg_wr && (i_reg_addr == mms_pkg::ADDR_STBY_CFG);
    assign wmode = i_reg_wdata[mms_pkg::MODE_LSB +: 2];
    assign busy = (state_reg == mms_pkg::ST_TEMP) || (state_reg == mms_pkg::ST_PRES)
                  || (state_reg == mms_pkg::ST_FILT);
    // A same-cycle write must take effect for a measurement started now
    assign osrs_eff = wr_ctrl ? i_reg_wdata[7:2] : osrs_reg;
    assign nt_eff = mms_pkg::osr_samples(osrs_eff[mms_pkg::OSRS_T_LSB-2 +: 3]);
    assign np_eff = mms_pkg::osr_samples(osrs_eff[mms_pkg::OSRS_P_LSB-2 +: 3]);
    assign nt_meas = mms_pkg::osr_samples(osrs_meas_reg[mms_pkg::OSRS_T_LSB-2 +: 3]);
    assign np_meas = mms_pkg::osr_samples(osrs_meas_reg[mms_pkg::OSRS_P_LSB-2 +: 3]);
    assign temp_us = mms_pkg::MEAS_BASE_US + mms_pkg::TEMP_SAMPLE_US * 22'(nt_eff);
    assign pres_us = (np_meas == 5'h00) ? 22'h00_0000
                     : mms_pkg::PRES_SAMPLE_US * 22'(np_meas) + mms_pkg::PRES_EXTRA_US;

    // Mode the register holds once the running measurement closes
    always_comb begin
        if (pend_reg) begin
            mode_after = pend_mode_reg;
        end else if (wr_ctrl) begin
            mode_after = wmode;
        end else if (mms_pkg::is_forced(mode_reg)) begin
            mode_after = mms_pkg::MODE_SLEEP;
        end else begin
            mode_after = mode_reg;
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            mms_pkg::ST_SLEEP: begin
                if (wr_ctrl && (wmode != mms_pkg::MODE_SLEEP)) begin
                    state_next = mms_pkg::ST_TEMP;
                end
            end
            mms_pkg::ST_TEMP: begin
                if (tmr_done) begin
                    state_next = (np_meas == 5'h00) ? mms_pkg::ST_FILT : mms_pkg::ST_PRES;
                end
            end
            mms_pkg::ST_PRES: begin
                if (tmr_done) begin
                    state_next = mms_pkg::ST_FILT;
                end
            end
            mms_pkg::ST_FILT: begin
                if (mode_after == mms_pkg::MODE_SLEEP) begin
                    state_next = mms_pkg::ST_SLEEP;
                end else if (mms_pkg::is_forced(mode_after)) begin
                    state_next = mms_pkg::ST_TEMP;
                end else begin
                    state_next = mms_pkg::ST_STBY;
                end
            end
            mms_pkg::ST_STBY: begin
                // Sleep or forced mode may be entered from standby at once
                if (wr_ctrl && (wmode == mms_pkg::MODE_SLEEP)) begin
                    state_next = mms_pkg::ST_SLEEP;
                end else if ((wr_ctrl && mms_pkg::is_forced(wmode)) || tmr_done) begin
                    state_next = mms_pkg::ST_TEMP;
                end
            end
            default: state_next = mms_pkg::ST_SLEEP;
        endcase
    end

    assign tmr_load = (state_next != state_reg) && (state_next != mms_pkg::ST_SLEEP)
                      && (state_next != mms_pkg::ST_FILT) || ((state_reg == mms_pkg::ST_FILT)
                      && (state_next == mms_pkg::ST_TEMP));

    always_comb begin
        case (state_next)
            mms_pkg::ST_TEMP: tmr_ticks = temp_us;
            mms_pkg::ST_PRES: tmr_ticks = pres_us;
            default: tmr_ticks = mms_pkg::STANDBY_US[cfg_reg[mms_pkg::IDLE_SEL_LSB +: 3]];
        endcase
    end

    mms_interval_timer #(
        .P_TICK_CYCLES(P_TICK_CYCLES)
    ) u_timer (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_load(tmr_load),
        .i_ticks(tmr_ticks),
        .o_done(tmr_done)
    );

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= mms_pkg::ST_SLEEP;
        end else begin
            state_reg <= state_next;
        end
    end

    // Mode field, deferral and drop of extra changes
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_reg <= mms_pkg::MEAS_CTRL_RESET[mms_pkg::MODE_LSB +: 2];
            pend_reg <= 1'b0;
            pend_mode_reg <= mms_pkg::MODE_SLEEP;
        end else if (state_reg == mms_pkg::ST_FILT) begin
            mode_reg <= mode_after;
            pend_reg <= 1'b0;
        end else if (wr_ctrl && busy) begin
            if (!pend_reg) begin
                pend_reg <= 1'b1;
                pend_mode_reg <= wmode;
            end
        end else if (wr_ctrl) begin
            mode_reg <= wmode;
        end
    end

    // Oversampling and standby config writes are honoured in every state
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            osrs_reg <= mms_pkg::MEAS_CTRL_RESET[7:2];
            cfg_reg <= mms_pkg::STBY_CFG_RESET;
        end else begin
            if (wr_ctrl) begin
                osrs_reg <= i_reg_wdata[7:2];
            end
            if (wr_cfg) begin
                cfg_reg <= i_reg_wdata;
            end
        end
    end

    // Oversampling settings frozen for the whole measurement
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            osrs_meas_reg <= 6'h00;
        end else if (state_next == mms_pkg::ST_TEMP && tmr_load) begin
            osrs_meas_reg <= osrs_eff;
        end
    end

    // Results are published together so a reader never sees a mixed pair
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            temp_hold_reg <= mms_pkg::SKIP_VALUE;
            o_temp_data <= mms_pkg::SKIP_VALUE;
            o_press_data <= mms_pkg::SKIP_VALUE;
            o_data_update <= 1'b0;
        end else begin
            o_data_update <= (state_reg == mms_pkg::ST_FILT);
            if (state_reg == mms_pkg::ST_TEMP && tmr_done) begin
                temp_hold_reg <= (nt_meas == 5'h00) ? mms_pkg::SKIP_VALUE : i_temp_adc;
            end
            if (state_reg == mms_pkg::ST_FILT) begin
                o_temp_data <= temp_hold_reg;
                o_press_data <= (np_meas == 5'h00) ? mms_pkg::SKIP_VALUE : i_press_adc;
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_addr == mms_pkg::ADDR_MEAS_CTRL) begin
            o_reg_rdata <= {osrs_reg, mode_reg};
        end else if (i_reg_addr == mms_pkg::ADDR_STBY_CFG) begin
            o_reg_rdata <= cfg_reg;
        end else begin
            o_reg_rdata <= 8'h00;
        end
    end

    assign o_temp_conv = (state_reg == mms_pkg::ST_TEMP) && (nt_meas != 5'h00);
    assign o_press_conv = (state_reg == mms_pkg::ST_PRES);
    assign o_filter_step = (state_reg == mms_pkg::ST_FILT) && (cfg_reg[mms_pkg::FILTER_LSB +: 3] != 3'h0);
    assign o_measuring = busy;
    assign o_mode_pending = pend_reg;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    a_sleep_quiet: assert property ((state_reg == mms_pkg::ST_SLEEP) |-> !o_temp_conv && !o_press_conv)
        else $error("conversion active in sleep");
    a_forced_single: assert property ((state_reg == mms_pkg::ST_FILT) && !pend_reg && !wr_ctrl
        && mms_pkg::is_forced(mode_reg) |=> (state_reg == mms_pkg::ST_SLEEP) && (mode_reg == mms_pkg::MODE_SLEEP))
        else $error("forced measurement did not return to sleep");
    a_normal_repeat: assert property ((state_reg == mms_pkg::ST_FILT)
        && (mode_after == mms_pkg::MODE_NORMAL) |=> (state_reg == mms_pkg::ST_STBY) ##0 o_data_update)
        else $error("normal mode did not enter standby after update");
    a_standby_length: assert property (tmr_load && (state_next == mms_pkg::ST_STBY)
        |-> tmr_ticks == mms_pkg::STANDBY_US[cfg_reg[mms_pkg::IDLE_SEL_LSB +: 3]])
        else $error("standby interval mismatch");
    a_defer_mode: assert property (wr_ctrl && busy && !pend_reg && (state_reg != mms_pkg::ST_FILT)
        |=> pend_reg && (mode_reg == $past(mode_reg)) && (pend_mode_reg == $past(wmode)))
        else $error("mode change not deferred");
    a_drop_extra: assert property (wr_ctrl && pend_reg && (state_reg != mms_pkg::ST_FILT)
        |=> $stable(pend_mode_reg) && $stable(mode_reg))
        else $error("second mode change not dropped");
    // Limits only bind up to two-fold temperature; higher settings may legally run longer
    a_meas_limit: assert property (tmr_load && (state_next == mms_pkg::ST_TEMP) && (nt_eff <= 5'h02)
        |-> (temp_us + mms_pkg::PRES_SAMPLE_US * 22'(np_eff) + mms_pkg::PRES_EXTRA_US) <= mms_pkg::MEAS_MAX_HIGH_US
        && ((nt_eff > 5'h01) || (np_eff > 5'h01)
        || (temp_us + mms_pkg::PRES_SAMPLE_US * 22'(np_eff) + mms_pkg::PRES_EXTRA_US) <= mms_pkg::MEAS_MAX_LOW_US))
        else $error("measurement time above limit");
    a_period_chain: assert property ((state_reg == mms_pkg::ST_STBY) && tmr_done && !wr_ctrl
        |=> (state_reg == mms_pkg::ST_TEMP))
        else $error("standby expiry did not start measurement");
    a_skip_value: assert property ((state_reg == mms_pkg::ST_FILT) && (nt_meas == 5'h00)
        |=> o_temp_data == mms_pkg::SKIP_VALUE)
        else $error("skipped temperature not set to fixed value");

    c_forced_done: cover property ((state_reg == mms_pkg::ST_FILT) ##1 (state_reg == mms_pkg::ST_SLEEP));
    c_normal_cycle: cover property ((state_reg == mms_pkg::ST_STBY) ##1 (state_reg == mms_pkg::ST_TEMP));
    c_pending_taken: cover property (pend_reg && (state_reg == mms_pkg::ST_FILT));
    c_extra_dropped: cover property (pend_reg && wr_ctrl && (state_reg != mms_pkg::ST_FILT));
endmodule : mms_scheduler

// [test/mms_host_model.sv]
`timescale 1ns/1ps
module mms_host_model (
    input wire logic i_ref_clk,
    input wire logic [7:0] i_reg_rdata,
    output logic o_reg_wr,
    output logic [7:0] o_reg_addr,
    output logic [7:0] o_reg_wdata
);
    initial begin
        o_reg_wr = 1'b0;
        o_reg_addr = 8'h00;
        o_reg_wdata = 8'h00;
    end
    // One-cycle strobe; callers rewrite forced for each sample and wait out the measurement
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_ref_clk);
        o_reg_wr <= 1'b1;
        o_reg_addr <= addr;
        o_reg_wdata <= data;
        @(posedge i_ref_clk);
        o_reg_wr <= 1'b0;
        // Released data must not keep looking valid
        o_reg_wdata <= ~data;
    endtask : wr
    // Read data lags the address by one register stage
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge i_ref_clk);
        o_reg_addr <= addr;
        @(posedge i_ref_clk);
        @(posedge i_ref_clk);
        #1;
        data = i_reg_rdata;
    endtask : rd
endmodule : mms_host_model

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
    logic i_ref_clk;
    logic i_rst;
    logic reg_wr;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [7:0] rdata;
    logic [19:0] temp_adc;
    logic [19:0] press_adc;
    logic o_temp_conv;
    logic o_press_conv;
    logic o_filter_step;
    logic o_data_update;
    logic [19:0] o_temp_data;
    logic [19:0] o_press_data;
    logic o_measuring;
    logic o_mode_pending;
    logic [39:0] exp_q[$];
    logic [39:0] e;
    int error_cnt = 0;
    int num_checks = 0;
    int seed = 66898;
    int cyc = 0;
    int meas_cnt = 0;
    int meas_len = 0;
    int last_upd = 0;
    int period = 0;
    int upd_cnt = 0;
    int tconv_cnt = 0;
    int pconv_cnt = 0;
    int filt_cnt = 0;
    int u;
    int t;

    mms_host_model host (.i_ref_clk(i_ref_clk), .i_reg_rdata(reg_rdata), .o_reg_wr(reg_wr), .o_reg_addr(reg_addr),
                         .o_reg_wdata(reg_wdata));
    mms_scheduler #(.P_TICK_CYCLES(1)) dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reg_wr(reg_wr),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .i_temp_adc(temp_adc),
        .i_press_adc(press_adc), .o_temp_conv(o_temp_conv), .o_press_conv(o_press_conv),
        .o_filter_step(o_filter_step),
        .o_data_update(o_data_update), .o_temp_data(o_temp_data), .o_press_data(o_press_data),
        .o_measuring(o_measuring), .o_mode_pending(o_mode_pending));

    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end

    task automatic results();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    task automatic check(input string name, input logic [39:0] exp, input logic [39:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Bounded wait for a result pulse, then one more edge so the monitor has logged it
    task automatic wait_upd(input int n);
        int k;
        k = 0;
        do begin
            @(posedge i_ref_clk);
            #1;
            k++;
        end while (o_data_update !== 1'b1 && k < n);
        if (o_data_update !== 1'b1) begin
            check("update wait", 1'b1, 1'b0);
            results();
        end
        @(posedge i_ref_clk);
        #1;
    endtask : wait_upd

    task automatic new_adc(input logic [19:0] tx);
        temp_adc <= 20'($random(seed));
        press_adc <= 20'($random(seed));
        @(posedge i_ref_clk);
        exp_q.push_back({tx === 20'h0_0000 ? temp_adc : mms_pkg::SKIP_VALUE, press_adc});
    endtask : new_adc

    // Monitor: every result pulse takes the oldest expected pair
    always @(posedge i_ref_clk) begin
        if (!i_rst) begin
            cyc <= cyc + 1;
            if (o_temp_conv === 1'b1) tconv_cnt <= tconv_cnt + 1;
            if (o_press_conv === 1'b1) pconv_cnt <= pconv_cnt + 1;
            if (o_filter_step === 1'b1) filt_cnt <= filt_cnt + 1;
            if (o_measuring === 1'b1) begin
                meas_cnt <= meas_cnt + 1;
            end else if (meas_cnt != 0) begin
                meas_len <= meas_cnt;
                meas_cnt <= 0;
            end
            if (o_data_update === 1'b1) begin
                period <= cyc - last_upd;
                last_upd <= cyc;
                upd_cnt <= upd_cnt + 1;
                e = (exp_q.size() > 0) ? exp_q.pop_front() : 40'hxx_xxxx_xxxx;
                check("temp data", {20'h0_0000, e[39:20]}, {20'h0_0000, o_temp_data});
                check("press data", {20'h0_0000, e[19:0]}, {20'h0_0000, o_press_data});
            end
        end
    end

    initial begin
        i_rst = 1'b1;
        temp_adc = 20'h0_0000;
        press_adc = 20'h0_0000;
        repeat (6) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(posedge i_ref_clk);
        #1;
        check("reset temp", 40'h00_0008_0000, {20'h0_0000, o_temp_data});
        check("reset measuring", 1'b0, o_measuring);
        host.rd(mms_pkg::ADDR_MEAS_CTRL, rdata);
        check("reset mode", mms_pkg::MEAS_CTRL_RESET, rdata);
        host.rd(mms_pkg::ADDR_STBY_CFG, rdata);
        check("reset cfg", mms_pkg::STBY_CFG_RESET, rdata);
        // Random settings while asleep must read back and start nothing
        u = $random(seed);
        host.wr(mms_pkg::ADDR_STBY_CFG, u[7:0]);
        host.wr(mms_pkg::ADDR_MEAS_CTRL, {u[15:10], 2'b00});
        host.rd(mms_pkg::ADDR_STBY_CFG, rdata);
        check("cfg rw", u[7:0], rdata);
        host.rd(mms_pkg::ADDR_MEAS_CTRL, rdata);
        check("ctrl rw", {u[15:10], 2'b00}, rdata);
        repeat (40) @(posedge i_ref_clk);
        #1;
        check("sleep idle", 2'b00, {o_measuring, o_temp_conv});
        host.wr(mms_pkg::ADDR_STBY_CFG, 8'h00);
        // Both forced codes: one measurement each, then back to sleep
        for (int c = 1; c <= 2; c++) begin
            t = tconv_cnt;
            u = pconv_cnt;
            new_adc(20'h0_0000);
            host.wr(mms_pkg::ADDR_MEAS_CTRL, {6'h09, c[1:0]});
            wait_upd(8000);
            check("meas len x1", 1'b1, meas_len >= 5501 && meas_len <= 5508 && meas_len <= 6400);
            check("temp conv len", 1'b1, tconv_cnt - t >= 3000 && tconv_cnt - t <= 3008);
            check("press conv len", 1'b1, pconv_cnt - u >= 2500 && pconv_cnt - u <= 2508);
            host.rd(mms_pkg::ADDR_MEAS_CTRL, rdata);
            check("forced to sleep", 8'h24, rdata);
            u = upd_cnt;
            repeat (6000) @(posedge i_ref_clk);
            check("no repeat", u, upd_cnt);
        end
        // Skipped temperature shortens the measurement and gives the fixed value
        t = tconv_cnt;
        new_adc(20'h0_0001);
        host.wr(mms_pkg::ADDR_MEAS_CTRL, 8'h05);
        wait_upd(8000);
        check("meas len skip", 1'b1, meas_len >= 3501 && meas_len <= 3508);
        check("no temp conv", t, tconv_cnt);
        // Normal mode with the shortest idle interval and the filter on
        host.wr(mms_pkg::ADDR_STBY_CFG, 8'h04);
        new_adc(20'h0_0000);
        host.wr(mms_pkg::ADDR_MEAS_CTRL, 8'h27);
        wait_upd(8000);
        exp_q.push_back({temp_adc, press_adc});
        wait_upd(8000);
        check("normal period", 1'b1, period >= 6001 && period <= 6012);
        exp_q.push_back({temp_adc, press_adc});
        for (t = 0; t < 1000 && o_measuring !== 1'b1; t++) begin
            @(posedge i_ref_clk);
            #1;
        end
        check("restart", 1'b1, o_measuring);
        if (o_measuring !== 1'b1) begin
            results();
        end
        host.wr(mms_pkg::ADDR_MEAS_CTRL, 8'h24);
        #1;
        check("pending", 1'b1, o_mode_pending);
        host.wr(mms_pkg::ADDR_MEAS_CTRL, 8'h25);
        host.rd(mms_pkg::ADDR_MEAS_CTRL, rdata);
        check("mode held", 2'b11, rdata[1:0]);
        wait_upd(8000);
        repeat (20) @(posedge i_ref_clk);
        #1;
        check("applied sleep", 2'b00, {o_measuring, o_mode_pending});
        host.rd(mms_pkg::ADDR_MEAS_CTRL, rdata);
        check("sleep mode", 8'h24, rdata);
        check("filter steps", 3, filt_cnt);
        check("queue empty", 0, exp_q.size());
        results();
    end
endmodule : tb
